// file: hw/sfwp_defs.vh
// constants for the serial flash write-protection block
// assumes 19-bit array addresses (512KB) and byte addresses on the register bus
`ifndef SFWP_DEFS_VH
`define SFWP_DEFS_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define SFWP_CMD_WRITE_LATCH_SET_CMD 8'h06
`define SFWP_CMD_WRDI 8'h04
`define SFWP_CMD_WRSR 8'h01
`define SFWP_CMD_PP 8'h02
`define SFWP_CMD_DPP 8'hA2
`define SFWP_CMD_PE 8'h81
`define SFWP_CMD_SE 8'h20
`define SFWP_CMD_HBE 8'h52
`define SFWP_CMD_BE 8'hD8
`define SFWP_CMD_CE1 8'h60
`define SFWP_CMD_CE2 8'hC7
`define SFWP_CMD_DPD 8'hB9
`define SFWP_CMD_RDPD 8'hAB
`define SFWP_CMD_SUSP1 8'h75
`define SFWP_CMD_SUSP2 8'hB0
`define SFWP_CMD_RESM1 8'h7A
`define SFWP_CMD_RESM2 8'h30
`define SFWP_CMD_RSTEN 8'h66
`define SFWP_CMD_RST 8'h99

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define SFWP_AW 19
`define SFWP_ADDR_MAX 19'h7FFFF
`define SFWP_MASK_PAGE 19'h000FF
`define SFWP_MASK_SECTOR 19'h00FFF
`define SFWP_MASK_HALF 19'h07FFF
`define SFWP_MASK_BLOCK 19'h0FFFF
`define SFWP_SIZE_4K 19'h01000
`define SFWP_SIZE_64K 19'h10000
`define SFWP_SIZE_32K 19'h08000

// ---------------------------------------------------------------
// operation kinds reported on the exec port
// ---------------------------------------------------------------
`define SFWP_KIND_NONE 3'h0
`define SFWP_KIND_PROG 3'h1
`define SFWP_KIND_PE 3'h2
`define SFWP_KIND_SE 3'h3
`define SFWP_KIND_HBE 3'h4
`define SFWP_KIND_BE 3'h5
`define SFWP_KIND_CE 3'h6
`define SFWP_KIND_WRSR 3'h7

// ---------------------------------------------------------------
// register map (byte addresses) and fields
// ---------------------------------------------------------------
`define SFWP_OFS_STATUS 4'h0
`define SFWP_OFS_CTRL 4'h4
`define SFWP_OFS_EXEC 4'h8
`define SFWP_CTRL_DONE_BIT 0
`define SFWP_SYNC_RST 4'hA

`endif

// file: hw/sfwp_prot_range.v
// protected address range decoder
// assumes level and invert bits come from registers on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_defs.vh"

module sfwp_prot_range (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // protect bits
  input wire [4:0] level_i,
  input wire invert_i,
  // protected range, registered
  output reg none_o,
  output reg [18:0] lo_o,
  output reg [18:0] hi_o
);

  reg [18:0] size;
  reg all_sel;
  reg bottom;

  // ---------------------------------------------------------------
  // plain region size
  // ---------------------------------------------------------------
  always @* begin
    size = 19'h00000;
    all_sel = 1'b0;
    bottom = level_i[3];
    if (!level_i[4]) begin
      if (level_i[2])
        all_sel = 1'b1;
      else if (level_i[1:0] != 2'b00)
        size = `SFWP_SIZE_64K << (level_i[1:0] - 2'b01);
    end else begin
      if (level_i[2:0] == 3'b111)
        all_sel = 1'b1;
      else if (level_i[2])
        size = `SFWP_SIZE_32K;
      else if (level_i[1:0] != 2'b00)
        size = `SFWP_SIZE_4K << (level_i[1:0] - 2'b01);
    end
  end

  // ---------------------------------------------------------------
  // complement and registering
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      none_o <= 1'b1;
      lo_o <= 19'h00000;
      hi_o <= 19'h00000;
    end else if (!invert_i) begin
      none_o <= ~all_sel & (size == 19'h00000);
      lo_o <= all_sel ? 19'h00000 : (bottom ? 19'h00000 : `SFWP_ADDR_MAX - size + 19'h00001);
      hi_o <= all_sel ? `SFWP_ADDR_MAX : (bottom ? size - 19'h00001 : `SFWP_ADDR_MAX);
    end else begin
      // empty code protects all, full code protects nothing
      none_o <= all_sel;
      lo_o <= (size == 19'h00000) ? 19'h00000 : (bottom ? size : 19'h00000);
      hi_o <= (size == 19'h00000) ? `SFWP_ADDR_MAX :
              (bottom ? `SFWP_ADDR_MAX : `SFWP_ADDR_MAX - size);
    end
  end

endmodule
`default_nettype wire

// file: hw/sfwp_core.v
// serial flash write-protection and suspend-status core
// assumes serial pins and wp pin are asynchronous; avalon-mm slave on core_clk_i
//
// How it works
// - erase suspend sets the erase-suspended flag, program suspend the program one.
// - resume, the two-byte software reset and a power cycle clear both suspend flags.
// - reset puts the command logic in standby so only whole commands change contents.
// - data-changing commands whose bit count is not whole bytes are rejected.
// - data-changing commands are accepted only while the write enable latch is set.
// - the five protect-level bits pick a region that can be read but not changed.
// - with wp low in hardware mode, invert, level and lock-mode bits cannot be written.
// - in deep power-down every command but release is ignored.
// - with invert 0 and bit4 0, codes pick 64KB, 128KB, 256KB top or bottom, or all.
// - with invert 0 and bit4 1, codes pick 4KB to 32KB top or bottom, or all for 111.
// - with invert 1 the protected range is the complement of the plain one.
// - with invert 1, code 000 protects all, and the full codes protect nothing.
// - program or erase touching any protected byte is ignored.
// - chip erase runs only when nothing is protected.
// - with the latch clear, status write, program and erase are refused.
// - the invert bit sits at status bit 14 and resets to 0.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_defs.vh"

module sfwp_core (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // serial pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  input wire wp_n_i,
  // array operation port
  output reg exec_pulse_o,
  output reg [2:0] exec_kind_o,
  output reg [18:0] exec_addr_o,
  output wire busy_o,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [18:0] op_mask;
    input [7:0] op;
    begin
      case (op)
        `SFWP_CMD_SE: op_mask = `SFWP_MASK_SECTOR;
        `SFWP_CMD_HBE: op_mask = `SFWP_MASK_HALF;
        `SFWP_CMD_BE: op_mask = `SFWP_MASK_BLOCK;
        default: op_mask = `SFWP_MASK_PAGE;
      endcase
    end
  endfunction

  function [2:0] op_kind;
    input [7:0] op;
    begin
      case (op)
        `SFWP_CMD_PP: op_kind = `SFWP_KIND_PROG;
        `SFWP_CMD_DPP: op_kind = `SFWP_KIND_PROG;
        `SFWP_CMD_PE: op_kind = `SFWP_KIND_PE;
        `SFWP_CMD_SE: op_kind = `SFWP_KIND_SE;
        `SFWP_CMD_HBE: op_kind = `SFWP_KIND_HBE;
        `SFWP_CMD_BE: op_kind = `SFWP_KIND_BE;
        `SFWP_CMD_CE1: op_kind = `SFWP_KIND_CE;
        `SFWP_CMD_CE2: op_kind = `SFWP_KIND_CE;
        default: op_kind = `SFWP_KIND_NONE;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers, order {wp, si, cs, sclk}
  // ---------------------------------------------------------------
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] sync3_reg;
  reg [3:0] lvl_reg;
  wire [3:0] agree = ~(sync2_reg ^ sync3_reg);
  wire [3:0] lvl_next = (agree & sync3_reg) | (~agree & lvl_reg);

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= `SFWP_SYNC_RST;
      sync2_reg <= `SFWP_SYNC_RST;
      sync3_reg <= `SFWP_SYNC_RST;
      lvl_reg <= `SFWP_SYNC_RST;
    end else begin
      sync1_reg <= {wp_n_i, si_i, cs_n_i, sclk_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= lvl_next;
    end
  end

  wire sclk_rise = lvl_next[0] & ~lvl_reg[0];
  wire cs_fall = ~lvl_next[1] & lvl_reg[1];
  wire cs_rise = lvl_next[1] & ~lvl_reg[1];
  wire si_lvl = lvl_next[2];
  wire wp_n_lvl = lvl_reg[3];

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  reg [2:0] bit_cnt_reg;
  reg [6:0] shift_reg;
  reg [3:0] nbytes_reg;
  reg [7:0] opcode_reg;
  reg [7:0] byte1_reg;
  reg [7:0] byte2_reg;
  reg [7:0] byte3_reg;
  wire [7:0] byte_now = {shift_reg, si_lvl};

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      nbytes_reg <= 4'h0;
      opcode_reg <= 8'h00;
      byte1_reg <= 8'h00;
      byte2_reg <= 8'h00;
      byte3_reg <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      nbytes_reg <= 4'h0;
    end else if (sclk_rise && !lvl_reg[1]) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_now[6:0];
      if (bit_cnt_reg == 3'h7) begin
        if (nbytes_reg != 4'hF)
          nbytes_reg <= nbytes_reg + 4'h1;
        case (nbytes_reg)
          4'h0: opcode_reg <= byte_now;
          4'h1: byte1_reg <= byte_now;
          4'h2: byte2_reg <= byte_now;
          4'h3: byte3_reg <= byte_now;
          default: byte3_reg <= byte3_reg;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // status bits and protection range
  // ---------------------------------------------------------------
  reg busy_reg;
  reg wel_reg;
  reg [4:0] bp_reg;
  reg status_lock_mode_bit0_reg;
  reg status_lock_mode_bit1_reg;
  reg cmp_reg;
  reg erase_suspended_flag_reg;
  reg program_suspended_flag_reg;
  reg dpd_reg;
  reg rst_en_reg;
  reg [2:0] rej_reg;
  wire prot_none;
  wire [18:0] prot_lo;
  wire [18:0] prot_hi;

  sfwp_prot_range u_range (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(bp_reg),
    .invert_i(cmp_reg),
    .none_o(prot_none),
    .lo_o(prot_lo),
    .hi_o(prot_hi)
  );

  wire [15:0] status_word = {erase_suspended_flag_reg, cmp_reg, 3'b000, program_suspended_flag_reg, 1'b0, status_lock_mode_bit1_reg,
                             status_lock_mode_bit0_reg, bp_reg, wel_reg, busy_reg};

  // ---------------------------------------------------------------
  // command decision at deselect
  // ---------------------------------------------------------------
  wire [18:0] cmd_addr = {byte1_reg[2:0], byte2_reg, byte3_reg};
  wire [18:0] cmd_lo = cmd_addr & ~op_mask(opcode_reg);
  wire [18:0] cmd_hi = cmd_addr | op_mask(opcode_reg);
  wire [2:0] cmd_kind = op_kind(opcode_reg);
  wire whole = (bit_cnt_reg == 3'h0) && (nbytes_reg != 4'h0);
  wire is_prog = (cmd_kind == `SFWP_KIND_PROG);
  wire is_ce = (cmd_kind == `SFWP_KIND_CE);
  wire is_arr = (cmd_kind != `SFWP_KIND_NONE);
  wire is_wrsr = (opcode_reg == `SFWP_CMD_WRSR);
  wire len_ok = is_prog ? (nbytes_reg >= 4'h5) :
                is_ce ? (nbytes_reg == 4'h1) :
                is_wrsr ? ((nbytes_reg == 4'h2) || (nbytes_reg == 4'h3)) :
                (nbytes_reg == 4'h4);
  // any overlap with the protected range
  wire hits_prot = ~prot_none & (cmd_lo <= prot_hi) & (cmd_hi >= prot_lo);
  // hardware lock, also power-cycle and permanent lock
  wire sr_locked = status_lock_mode_bit1_reg | (status_lock_mode_bit0_reg & ~wp_n_lvl);
  // a partial byte never reaches the decision
  wire done_frame = cs_rise & whole;
  wire susp_cmd = (opcode_reg == `SFWP_CMD_SUSP1) || (opcode_reg == `SFWP_CMD_SUSP2);
  wire resm_cmd = (opcode_reg == `SFWP_CMD_RESM1) || (opcode_reg == `SFWP_CMD_RESM2);
  reg [2:0] susp_kind_reg;

  // ---------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ---------------------------------------------------------------
  reg ack_reg;
  wire req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  wire bus_done = avs_write_i & ack_reg & (avs_address_i == `SFWP_OFS_CTRL) &
                  avs_writedata_i[`SFWP_CTRL_DONE_BIT];
  assign busy_o = busy_reg;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read_i && !ack_reg) begin
        case (avs_address_i)
          `SFWP_OFS_STATUS: avs_readdata_o <= {16'h0000, status_word};
          `SFWP_OFS_EXEC: avs_readdata_o <= {4'h0, dpd_reg, exec_kind_o, 2'b00, rej_reg,
                                            exec_addr_o};
          default: avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      bp_reg <= 5'h00;
      status_lock_mode_bit0_reg <= 1'b0;
      status_lock_mode_bit1_reg <= 1'b0;
      cmp_reg <= 1'b0;
      erase_suspended_flag_reg <= 1'b0;
      program_suspended_flag_reg <= 1'b0;
      dpd_reg <= 1'b0;
      rst_en_reg <= 1'b0;
      rej_reg <= 3'h0;
      susp_kind_reg <= `SFWP_KIND_NONE;
      exec_pulse_o <= 1'b0;
      exec_kind_o <= `SFWP_KIND_NONE;
      exec_addr_o <= 19'h00000;
    end else begin
      exec_pulse_o <= 1'b0;
      // software ends the array operation; a new start below wins
      if (bus_done)
        busy_reg <= 1'b0;
      // rejected when the frame ends mid-byte
      if (cs_rise && !whole && !dpd_reg && (is_arr || is_wrsr) && nbytes_reg != 4'h0)
        rej_reg <= 3'b100;
      if (done_frame) begin
        rst_en_reg <= (opcode_reg == `SFWP_CMD_RSTEN);
        if (dpd_reg) begin
          if (opcode_reg == `SFWP_CMD_RDPD)
            dpd_reg <= 1'b0;
        end else if (susp_cmd) begin
          // flag follows the kind of operation held
          if (busy_reg && susp_kind_reg == `SFWP_KIND_PROG) begin
            program_suspended_flag_reg <= 1'b1;
            busy_reg <= 1'b0;
          end else if (busy_reg && susp_kind_reg != `SFWP_KIND_WRSR) begin
            erase_suspended_flag_reg <= 1'b1;
            busy_reg <= 1'b0;
          end
        end else if (resm_cmd) begin
          erase_suspended_flag_reg <= 1'b0;
          program_suspended_flag_reg <= 1'b0;
          if (erase_suspended_flag_reg || program_suspended_flag_reg)
            busy_reg <= 1'b1;
        end else if (opcode_reg == `SFWP_CMD_RST) begin
          if (rst_en_reg) begin
            erase_suspended_flag_reg <= 1'b0;
            program_suspended_flag_reg <= 1'b0;
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
          end
        end else if (busy_reg) begin
          // commands other than suspend, resume and reset are dropped while the array is busy
          rej_reg <= rej_reg;
        end else if (opcode_reg == `SFWP_CMD_WRITE_LATCH_SET_CMD && nbytes_reg == 4'h1) begin
          // latch set by its own command
          wel_reg <= 1'b1;
        end else if (opcode_reg == `SFWP_CMD_WRDI && nbytes_reg == 4'h1) begin
          wel_reg <= 1'b0;
        end else if (opcode_reg == `SFWP_CMD_DPD && nbytes_reg == 4'h1) begin
          dpd_reg <= 1'b1;
        end else if (is_wrsr || is_arr) begin
          if (!len_ok) begin
            rej_reg <= 3'b100;
          end else if (!wel_reg) begin
            rej_reg <= 3'b010;
          end else if (is_wrsr && sr_locked) begin
            rej_reg <= 3'b001;
          end else if (is_ce && !prot_none) begin
            // chip erase needs an unprotected array
            rej_reg <= 3'b001;
          end else if (is_arr && !is_ce && hits_prot) begin
            rej_reg <= 3'b001;
          end else begin
            rej_reg <= 3'b000;
            wel_reg <= 1'b0;
            busy_reg <= 1'b1;
            exec_pulse_o <= 1'b1;
            exec_kind_o <= is_wrsr ? `SFWP_KIND_WRSR : cmd_kind;
            exec_addr_o <= is_ce ? 19'h00000 : cmd_lo;
            susp_kind_reg <= is_wrsr ? `SFWP_KIND_WRSR : cmd_kind;
            if (is_wrsr) begin
              status_lock_mode_bit0_reg <= byte1_reg[7];
              bp_reg <= byte1_reg[6:2];
              if (nbytes_reg == 4'h3) begin
                status_lock_mode_bit1_reg <= byte2_reg[0];
                cmp_reg <= byte2_reg[6];
              end
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: test/sfwp_props.sv
// port checks for the flash write-protection core
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_defs.vh"

module sfwp_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial select
  input wire logic cs_n_i,
  // array port
  input wire logic exec_pulse_o,
  input wire logic [2:0] exec_kind_o,
  input wire logic [18:0] exec_addr_o,
  input wire logic busy_o,
  // register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire req = avs_read_i | avs_write_i;
  wire done_wr = avs_write_i & ~avs_waitrequest_o & (avs_address_i == `SFWP_OFS_CTRL);
  // -------
  // checks
  // -------
  a_bus_one_wait: assert property (req && !$past(req) |-> avs_waitrequest_o ##1
    !avs_waitrequest_o) else $error("bus answer not after one wait cycle");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  a_frame_closed: assert property (exec_pulse_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("operation started inside a frame");
  a_pulse_single: assert property (exec_pulse_o |=> !exec_pulse_o)
    else $error("start pulse longer than one cycle");
  a_start_busy: assert property (exec_pulse_o |-> ##[0:1] busy_o)
    else $error("started operation without busy");
  a_result_hold: assert property (!exec_pulse_o ##1 !exec_pulse_o |->
    $stable(exec_kind_o) && $stable(exec_addr_o)) else $error("result moved without a start");
  a_chip_base: assert property (exec_pulse_o && exec_kind_o == `SFWP_KIND_CE |->
    exec_addr_o == 19'h00000) else $error("chip erase base not zero");
  a_page_align: assert property (exec_pulse_o && exec_kind_o == `SFWP_KIND_PROG |->
    exec_addr_o[7:0] == 8'h00) else $error("program range not page aligned");
  a_sector_align: assert property (exec_pulse_o && exec_kind_o == `SFWP_KIND_SE |->
    exec_addr_o[11:0] == 12'h000) else $error("sector range not aligned");
  a_done_clear: assert property (done_wr && avs_writedata_i[`SFWP_CTRL_DONE_BIT] &&
    !exec_pulse_o |=> !busy_o || exec_pulse_o) else $error("done did not clear busy");
  c_sector: cover property (exec_pulse_o && exec_kind_o == `SFWP_KIND_SE);
  c_chip: cover property (exec_pulse_o && exec_kind_o == `SFWP_KIND_CE);
  c_done: cover property ($fell(busy_o));
endmodule

bind sfwp_core sfwp_props u_props (.core_clk_i, .rst_n_i, .cs_n_i, .exec_pulse_o,
  .exec_kind_o, .exec_addr_o, .busy_o, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);

`default_nettype wire

// file: test/sfwp_host.sv
// host serial controller model, mode 0, msb first
// assumes the bench calls frame and nothing else drives the pins
`timescale 1ns/100ps
`default_nettype none

module sfwp_host (
  // serial pins
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b1;
  end
  // n bits from bit 39 down; a short n is a commanded bad length
  // bit count chosen
  task automatic frame(input logic [39:0] d, input int n, input bit slow);
    int i;
    // keeps every pin change 1 ns off the core clock edges
    #1;
    cs_n_o = 1'b0;
    for (i = 0; i < n; i++) begin
      si_o = d[39 - i];
      #40;
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
      if (slow) #80;
    end
    // released data must not look held
    si_o = ~si_o;
    #40;
    cs_n_o = 1'b1;
    #199;
  endtask
endmodule

`default_nettype wire

// file: test/sfwp_core_tb_top.sv
// self-checking bench for the flash write-protection core
// assumes the host model owns the serial pins, the bench owns bus and wp
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_defs.vh"

module sfwp_core_tb_top;
  logic clk;
  logic rst_n;
  logic wp_n;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] q;
  wire sclk;
  wire cs_n;
  wire si;
  wire pulse;
  wire [2:0] kind;
  wire [18:0] eaddr;
  wire busy;
  wire [31:0] rdata;
  wire waitreq;
  int bad_count = 0;
  int cmp_count = 0;
  int pulses = 0;

  sfwp_host HOST (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));
  sfwp_core DUT (.core_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n), .exec_pulse_o(pulse), .exec_kind_o(kind),
    .exec_addr_o(eaddr), .busy_o(busy), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pulse === 1'b1) pulses <= pulses + 1;
  end
  // -------
  // helpers
  // -------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // waitrequest and read data taken at the same rising edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) begin
      bad_count++;
      end_of_test;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op);
    HOST.frame({op, 32'h0}, 8, 1'b0);
  endtask
  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
    cmd(`SFWP_CMD_WRITE_LATCH_SET_CMD);
    HOST.frame({`SFWP_CMD_WRSR, lo, hi, 16'h0}, 24, 1'b0);
    bus(`SFWP_OFS_CTRL, 1'b1, 32'h1);
  endtask
  task automatic try_op(input logic [7:0] op, input logic [18:0] a, input int n,
      input logic en, input logic [2:0] k, input logic [2:0] rj);
    int p;
    logic ok;
    logic [21:0] old;
    p = pulses;
    ok = (rj == 3'h0);
    bus(`SFWP_OFS_EXEC, 1'b0, 32'h0);
    old = {q[26:24], q[18:0]};
    if (en) cmd(`SFWP_CMD_WRITE_LATCH_SET_CMD);
    HOST.frame({op, 5'h00, a, 8'hA5}, n, 1'b0);
    bus(`SFWP_OFS_EXEC, 1'b0, 32'h0);
    chk(32'(pulses - p), {31'h0, ok});
    chk({31'h0, busy}, {31'h0, ok});
    chk({q[26:24], q[21:0]}, ok ? {k, rj, a} : {old[21:19], rj, old[18:0]});
    chk({10'h0, kind, eaddr}, {10'h0, (ok ? {k, a} : old)});
    bus(`SFWP_OFS_CTRL, 1'b1, 32'h1);
  endtask
  task automatic prot(input logic inv, input logic [4:0] lvl, input logic [18:0] a,
      input logic rej);
    wrsr({1'b0, lvl, 2'b00}, {1'b0, inv, 6'h00});
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({26'h0, q[14], q[6:2]}, {26'h0, inv, lvl});
    try_op(`SFWP_CMD_SE, a, 32, 1'b1, `SFWP_KIND_SE, {2'b00, rej});
  endtask
  // -------
  // scenarios
  // -------
  task automatic t_reset;
    bus(`SFWP_OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
    bus(4'hC, 1'b1, 32'hFFFF_FFFF);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk(q, 32'h0000_0000);
    bus(4'hC, 1'b0, 32'h0);
    chk(q, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_latch;
    try_op(`SFWP_CMD_PP, 19'h12300, 40, 1'b0, `SFWP_KIND_PROG, 3'h2);
    try_op(`SFWP_CMD_PP, 19'h12300, 39, 1'b1, `SFWP_KIND_PROG, 3'h4);
    try_op(`SFWP_CMD_SE, 19'h12000, 31, 1'b1, `SFWP_KIND_SE, 3'h4);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    try_op(`SFWP_CMD_PP, 19'h12300, 40, 1'b1, `SFWP_KIND_PROG, 3'h0);
    $display("latch test done");
  endtask
  task automatic t_prot;
    prot(1'b0, 5'h01, 19'h70000, 1'b1);
    prot(1'b0, 5'h01, 19'h6F000, 1'b0);
    prot(1'b0, 5'h09, 19'h0F000, 1'b1);
    prot(1'b0, 5'h09, 19'h10000, 1'b0);
    prot(1'b0, 5'h04, 19'h00000, 1'b1);
    prot(1'b0, 5'h11, 19'h7F000, 1'b1);
    prot(1'b0, 5'h11, 19'h7E000, 1'b0);
    try_op(`SFWP_CMD_BE, 19'h70000, 32, 1'b1, `SFWP_KIND_BE, 3'h1);
    prot(1'b0, 5'h1D, 19'h07000, 1'b1);
    prot(1'b0, 5'h1D, 19'h08000, 1'b0);
    prot(1'b0, 5'h17, 19'h40000, 1'b1);
    prot(1'b1, 5'h01, 19'h6F000, 1'b1);
    prot(1'b1, 5'h01, 19'h70000, 1'b0);
    prot(1'b1, 5'h19, 19'h01000, 1'b1);
    prot(1'b1, 5'h19, 19'h00000, 1'b0);
    prot(1'b1, 5'h00, 19'h7F000, 1'b1);
    prot(1'b1, 5'h04, 19'h00000, 1'b0);
    prot(1'b1, 5'h17, 19'h40000, 1'b0);
    wrsr(8'h44, 8'h00);
    try_op(`SFWP_CMD_CE1, 19'h0, 8, 1'b1, `SFWP_KIND_CE, 3'h1);
    wrsr(8'h00, 8'h00);
    try_op(`SFWP_CMD_CE2, 19'h0, 8, 1'b1, `SFWP_KIND_CE, 3'h0);
    $display("protection test done");
  endtask
  task automatic t_lock;
    wrsr(8'h80, 8'h00);
    @(posedge clk);
    wp_n <= 1'b0;
    wrsr(8'h84, 8'h40);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk(q & 32'h0000_40FC, 32'h0000_0080);
    @(posedge clk);
    wp_n <= 1'b1;
    wrsr(8'h04, 8'h00);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk(q & 32'h0000_40FC, 32'h0000_0004);
    wrsr(8'h00, 8'h00);
    $display("lock test done");
  endtask
  task automatic t_dpd;
    cmd(`SFWP_CMD_WRDI);
    cmd(`SFWP_CMD_DPD);
    cmd(`SFWP_CMD_WRITE_LATCH_SET_CMD);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[1]}, 32'h0);
    bus(`SFWP_OFS_EXEC, 1'b0, 32'h0);
    chk({31'h0, q[27]}, 32'h1);
    HOST.frame({`SFWP_CMD_RDPD, 32'h0}, 8, 1'b1);
    cmd(`SFWP_CMD_WRITE_LATCH_SET_CMD);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    $display("power-down test done");
  endtask
  // resume code 00 stands for a power cycle through reset
  task automatic susp(input logic [7:0] op, input logic [7:0] sc, input logic [7:0] rc,
      input int b);
    cmd(`SFWP_CMD_WRITE_LATCH_SET_CMD);
    HOST.frame({op, 5'h00, 19'h21000, 8'h5A}, (op == `SFWP_CMD_PP) ? 40 : 32, 1'b0);
    cmd(sc);
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({30'h0, q[b], busy}, 32'h2);
    if (rc == 8'h00) begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
    end else begin
      if (rc == `SFWP_CMD_RSTEN) cmd(rc);
      cmd((rc == `SFWP_CMD_RSTEN) ? `SFWP_CMD_RST : rc);
    end
    bus(`SFWP_OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[b]}, 32'h0);
    bus(`SFWP_OFS_CTRL, 1'b1, 32'h1);
  endtask
  task automatic t_susp;
    susp(`SFWP_CMD_PP, `SFWP_CMD_SUSP1, `SFWP_CMD_RESM1, 10);
    susp(`SFWP_CMD_SE, `SFWP_CMD_SUSP2, `SFWP_CMD_RESM2, 15);
    susp(`SFWP_CMD_PP, `SFWP_CMD_SUSP2, `SFWP_CMD_RSTEN, 10);
    susp(`SFWP_CMD_SE, `SFWP_CMD_SUSP1, 8'h00, 15);
    $display("suspend test done");
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_prot();
    t_lock();
    t_dpd();
    t_susp();
    end_of_test();
  end
endmodule

`default_nettype wire
